// >>> rtl/rca_top.sv
// Clock/calendar with alarm, seconds/alarm output pin and a
// classic Wishbone register slave. Assumes xtal_i is a 32.768 kHz
// crystal clock from a pin; por_i and rst_i are on clk_i.
//
// How it works
// - Enable runs clock; enable write needs unlock
// - Time window writes only when unlocked
// - Ripple flag set near second rollover
// - Half flag; cleared by seconds write
// - Pin driven only with output enable
// - Time pointer counts down, stops at zero
// - Time pointer picks window register pair
// - Per-minute trim of four pulses per unit
// - Config word cleared only at power-on
// - Source select: seconds clock or alarm
// - One-shot alarm disables itself after event
// - Chime wraps repeat count, else stops
// - Mask code picks alarm interval
// - Yearly code; reserved codes never fire
// - Alarm pointer counts down, stops at zero
// - Alarm pointer picks alarm register pair
// - Repeat count decrements on each event while nonzero
// - Year holds two BCD digits, locked
// - Month/day field layout
// - Weekday/hour field layout
// - Minute/second field layout
// - Leap year and weekday in hardware
// - Any window read moves its pointer while nonzero
// - Interrupt pulse on every alarm event
// - Alarm pulse toggles on each event
`timescale 1ns/1ps
`default_nettype none
module rca_top #(
  parameter int ADDR_W = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic por_i,
  input wire logic xtal_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [rca_pkg::SEL_W-1:0] wb_sel_i,
  input wire logic [rca_pkg::DATA_W-1:0] wb_dat_i,
  output logic [rca_pkg::DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  output logic rtc_pin_o,
  output logic rtc_pin_oe_n_o,
  output logic alarm_irq_o
);
  import rca_pkg::*;

  typedef struct packed {
    logic xs1;
    logic xs2;
    logic xs3;
    logic [15:0] cnt;
    logic en;
    logic wren;
    logic oe;
    logic [1:0] tptr;
    logic [7:0] cal;
    logic secsel;
    logic padbuf;
    logic alen;
    logic chime;
    logic [3:0] alarm_interval_mask;
    logic [1:0] aptr;
    logic [7:0] alarm_repeat_count;
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hr;
    logic [7:0] day;
    logic [7:0] mon;
    logic [7:0] yr;
    logic [2:0] weekday_digit;
    logic [7:0] asec;
    logic [7:0] amin;
    logic [7:0] ahr;
    logic [7:0] aday;
    logic [7:0] amon;
    logic [2:0] awday;
    logic chk;
    logic apulse;
    logic irq;
    logic pin;
    logic oe_n;
    logic ack;
    logic [31:0] dat;
  } rca_state_s;

  rca_state_s q;
  rca_state_s next;

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      return {v[7:4] + 4'h1, 4'h0};
    end
    return v + 8'h01;
  endfunction

  function automatic logic [7:0] last_day(input logic [7:0] m,
                                          input logic [7:0] y);
    logic [1:0] r;
    // Year mod 4 from BCD: 10*tens is 2*tens mod 4
    r = y[1:0] + {y[4], 1'b0};
    case (m)
      MON_FEB: return (r == 2'h0) ? DAY_29 : DAY_28;
      MON_APR, MON_JUN, MON_SEP, MON_NOV: return DAY_30;
      default: return DAY_31;
    endcase
  endfunction

  logic pulse;
  logic sec_tick;
  logic half_tick;
  logic half;
  logic ripple;
  logic acc;
  logic wr;
  logic hi;
  logic lo;
  logic evt;
  logic m;
  logic [7:0] reg_off;
  logic [15:0] tval;
  logic [15:0] aval;
  logic [15:0] cal_load;

  assign pulse = q.xs2 & ~q.xs3;
  assign sec_tick = pulse & q.en & (q.cnt == CNT_SEC_LAST);
  assign half_tick = pulse & q.en & (q.cnt == CNT_HALF - 16'h1);
  assign half = q.cnt >= CNT_HALF;
  assign ripple = q.en & (q.cnt >= CNT_RIPPLE);
  assign cal_load = CNT_BIAS + {{6{q.cal[7]}}, q.cal, 2'b00};
  assign acc = wb_cyc_i & wb_stb_i & ~q.ack;
  assign wr = acc & wb_we_i;
  assign hi = wb_sel_i[1];
  assign lo = wb_sel_i[0];
  assign reg_off = {wb_adr_i[7:2], 2'b00};

  // year in low byte, upper zero
  always_comb begin
    case (q.tptr)
      2'b00: tval = {q.min & M_MS, q.sec & M_MS};
      2'b01: tval = {5'h00, q.weekday_digit, q.hr & M_HD};
      2'b10: tval = {q.mon & M_MON, q.day & M_HD};
      default: tval = {8'h00, q.yr};
    endcase
  end

  always_comb begin
    case (q.aptr)
      2'b00: aval = {q.amin, q.asec};
      2'b01: aval = {5'h00, q.awday, q.ahr};
      2'b10: aval = {q.amon, q.aday};
      default: aval = 16'h0000;
    endcase
  end

  always_comb begin
    case (q.alarm_interval_mask)
      AM_HALF, AM_SEC: m = 1'b1;
      AM_10S: m = q.asec[3:0] == q.sec[3:0];
      AM_MIN: m = q.asec == q.sec;
      AM_10M: m = q.asec == q.sec && q.amin[3:0] == q.min[3:0];
      AM_HOUR: m = q.asec == q.sec && q.amin == q.min;
      AM_DAY: m = q.asec == q.sec && q.amin == q.min
                  && q.ahr == q.hr;
      AM_WEEK: m = q.asec == q.sec && q.amin == q.min
                   && q.ahr == q.hr && q.awday == q.weekday_digit;
      AM_MONTH: m = q.asec == q.sec && q.amin == q.min
                    && q.ahr == q.hr && q.aday == q.day;
      AM_YEAR: m = q.asec == q.sec && q.amin == q.min
                   && q.ahr == q.hr && q.aday == q.day
                   && q.amon == q.mon;
      default: m = 1'b0;
    endcase
  end

  // Compared one cycle after the second tick, on the new time
  assign evt = q.alen & ((q.alarm_interval_mask == AM_HALF & half_tick) |
                         (q.chk & m));

  always_comb begin
    next = q;
    next.xs1 = xtal_i;
    next.xs2 = q.xs1;
    next.xs3 = q.xs2;
    next.chk = 1'b0;
    next.irq = 1'b0;
    next.ack = acc;
    // BCD time and date with carries
    if (sec_tick) begin
      next.chk = 1'b1;
      next.cnt = (q.sec == SEC_MAX) ? cal_load : CNT_BIAS;
      if (q.sec != SEC_MAX) begin
        next.sec = bcd_inc(q.sec);
      end else begin
        next.sec = RST_ZERO;
        if (q.min != SEC_MAX) begin
          next.min = bcd_inc(q.min);
        end else begin
          next.min = RST_ZERO;
          if (q.hr != HR_MAX) begin
            next.hr = bcd_inc(q.hr);
          end else begin
            next.hr = RST_ZERO;
            next.weekday_digit = (q.weekday_digit == WEEKDAY_DIGIT_MAX) ? 3'h0 : q.weekday_digit + 3'h1;
            if (q.day != last_day(q.mon, q.yr)) begin
              next.day = bcd_inc(q.day);
            end else begin
              next.day = RST_ONE;
              if (q.mon != MON_MAX) begin
                next.mon = bcd_inc(q.mon);
              end else begin
                next.mon = RST_ONE;
                next.yr = (q.yr == YR_MAX) ? RST_ZERO : bcd_inc(q.yr);
              end
            end
          end
        end
      end
    end else if (pulse & q.en) begin
      next.cnt = q.cnt + 16'h0001;
    end
    if (evt) begin
      next.irq = 1'b1;
      next.apulse = ~q.apulse;
      if (q.alarm_repeat_count != RST_ZERO) begin
        next.alarm_repeat_count = q.alarm_repeat_count - 8'h01;
      end else if (q.chime) begin
        next.alarm_repeat_count = RPT_MAX;
      end else begin
        next.alen = 1'b0;
      end
    end
    if (acc) begin
      next.dat = '0;
      case (reg_off)
        OFF_CFG: begin
          next.dat[15:0] = {q.en, 1'b0, q.wren, ripple, half, q.oe,
                            q.tptr, q.cal};
          if (wr & hi) begin
            if (q.wren) begin
              next.en = wb_dat_i[CFG_EN];
            end
            next.wren = wb_dat_i[CFG_WREN];
            next.oe = wb_dat_i[CFG_OE];
            next.tptr = wb_dat_i[PTR_HI:PTR_LO];
          end
          if (wr & lo) begin
            next.cal = wb_dat_i[7:0];
          end
        end
        OFF_PAD: begin
          next.dat[1:0] = {q.secsel, q.padbuf};
          if (wr & lo) begin
            next.secsel = wb_dat_i[PAD_SECSEL];
            next.padbuf = wb_dat_i[PAD_BUF];
          end
        end
        OFF_ALM: begin
          next.dat[15:0] = {q.alen, q.chime, q.alarm_interval_mask, q.aptr, q.alarm_repeat_count};
          if (wr & hi) begin
            next.alen = wb_dat_i[ALM_EN];
            next.chime = wb_dat_i[ALM_CHIME];
            next.alarm_interval_mask = wb_dat_i[MASK_HI:MASK_LO];
            next.aptr = wb_dat_i[PTR_HI:PTR_LO];
          end
          if (wr & lo) begin
            next.alarm_repeat_count = wb_dat_i[7:0];
          end
        end
        OFF_TWIN: begin
          next.dat[15:0] = tval;
          if (wr & q.wren) begin
            case (q.tptr)
              2'b00: begin
                if (hi) begin
                  next.min = wb_dat_i[15:8] & M_MS;
                end
                if (lo) begin
                  next.sec = wb_dat_i[7:0] & M_MS;
                  next.cnt = CNT_BIAS;
                end
              end
              2'b01: begin
                if (hi) begin
                  next.weekday_digit = wb_dat_i[10:8] & M_WD;
                end
                if (lo) begin
                  next.hr = wb_dat_i[7:0] & M_HD;
                end
              end
              2'b10: begin
                if (hi) begin
                  next.mon = wb_dat_i[15:8] & M_MON;
                end
                if (lo) begin
                  next.day = wb_dat_i[7:0] & M_HD;
                end
              end
              default: begin
                if (lo) begin
                  next.yr = wb_dat_i[7:0];
                end
              end
            endcase
          end
          // countdown on read or high-byte write, hold at zero
          if ((!wb_we_i | hi) && q.tptr != 2'b00) begin
            next.tptr = q.tptr - 2'b01;
          end
        end
        OFF_AWIN: begin
          next.dat[15:0] = aval;
          if (wr) begin
            case (q.aptr)
              2'b00: begin
                if (hi) begin
                  next.amin = wb_dat_i[15:8] & M_MS;
                end
                if (lo) begin
                  next.asec = wb_dat_i[7:0] & M_MS;
                end
              end
              2'b01: begin
                if (hi) begin
                  next.awday = wb_dat_i[10:8] & M_WD;
                end
                if (lo) begin
                  next.ahr = wb_dat_i[7:0] & M_HD;
                end
              end
              2'b10: begin
                if (hi) begin
                  next.amon = wb_dat_i[15:8] & M_MON;
                end
                if (lo) begin
                  next.aday = wb_dat_i[7:0] & M_HD;
                end
              end
              default: begin
              end
            endcase
          end
          if ((!wb_we_i | hi) && q.aptr != 2'b00) begin
            next.aptr = q.aptr - 2'b01;
          end
        end
        default: begin
        end
      endcase
    end
    if (rst_i | por_i) begin
      next.ack = 1'b0;
      next.dat = '0;
      next.irq = 1'b0;
      next.chk = 1'b0;
      next.apulse = 1'b0;
      next.secsel = 1'b0;
      next.padbuf = 1'b0;
      next.alen = 1'b0;
      next.chime = 1'b0;
      next.alarm_interval_mask = AM_HALF;
      next.aptr = 2'b00;
      next.alarm_repeat_count = RST_ZERO;
    end
    // config and time kept over plain reset
    if (por_i) begin
      next.en = 1'b0;
      next.wren = 1'b0;
      next.oe = 1'b0;
      next.tptr = 2'b00;
      next.cal = RST_ZERO;
      next.cnt = CNT_BIAS;
      next.xs1 = 1'b0;
      next.xs2 = 1'b0;
      next.xs3 = 1'b0;
      next.sec = RST_ZERO;
      next.min = RST_ZERO;
      next.hr = RST_ZERO;
      next.day = RST_ONE;
      next.mon = RST_ONE;
      next.yr = RST_ZERO;
      next.weekday_digit = RST_WEEKDAY_DIGIT;
      next.asec = RST_ZERO;
      next.amin = RST_ZERO;
      next.ahr = RST_ZERO;
      next.aday = RST_ONE;
      next.amon = RST_ONE;
      next.awday = 3'h0;
    end
    next.pin = next.secsel ? ~(next.cnt >= CNT_HALF) : next.apulse;
    next.oe_n = ~next.oe;
  end

  always_ff @(posedge clk_i) begin
    q <= next;
  end

  assign wb_dat_o = q.dat;
  assign wb_ack_o = q.ack;
  assign rtc_pin_o = q.pin;
  assign rtc_pin_oe_n_o = q.oe_n;
  assign alarm_irq_o = q.irq;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i || por_i);

  logic cfg_hi_wr;
  logic twin_acc;
  logic awin_acc;
  logic alm_wr;
  assign cfg_hi_wr = wr & hi & reg_off == OFF_CFG;
  assign twin_acc = acc & reg_off == OFF_TWIN & (!wb_we_i | hi);
  assign awin_acc = acc & reg_off == OFF_AWIN & (!wb_we_i | hi);
  assign alm_wr = wr & reg_off == OFF_ALM;

  chk_en_locked: assert property (
    cfg_hi_wr && !q.wren |=> q.en == $past(q.en))
    else $error("enable changed while locked");
  chk_win_locked: assert property (
    wr && reg_off == OFF_TWIN && !q.wren && !sec_tick
    |=> $stable(q.sec) && $stable(q.min) && $stable(q.yr))
    else $error("time window written while locked");
  chk_half_clear: assert property (
    wr && lo && reg_off == OFF_TWIN && q.wren && q.tptr == 2'b00
    |=> !half)
    else $error("half flag not cleared by seconds write");
  chk_pin_release: assert property (
    !q.oe && !$past(q.oe) |-> rtc_pin_oe_n_o)
    else $error("pin driven while output disabled");
  chk_tptr_step: assert property (
    twin_acc && q.tptr != 2'b00 && !cfg_hi_wr
    |=> q.tptr == $past(q.tptr) - 2'b01)
    else $error("time pointer did not step down");
  chk_tptr_hold: assert property (
    twin_acc && q.tptr == 2'b00 |=> q.tptr == 2'b00)
    else $error("time pointer left zero");
  chk_cal_load: assert property (
    sec_tick && q.sec == SEC_MAX && !acc |=> q.cnt == $past(cal_load))
    else $error("minute trim not loaded");
  chk_alarm_off: assert property (
    evt && q.alarm_repeat_count == RST_ZERO && !q.chime && !alm_wr |=> !q.alen)
    else $error("one-shot alarm stayed enabled");
  chk_chime_wrap: assert property (
    evt && q.alarm_repeat_count == RST_ZERO && q.chime && !alm_wr
    |=> q.alarm_repeat_count == RPT_MAX)
    else $error("chime did not wrap repeat count");
  chk_aptr_step: assert property (
    awin_acc && q.aptr != 2'b00 && !alm_wr
    |=> q.aptr == $past(q.aptr) - 2'b01)
    else $error("alarm pointer did not step down");
  chk_rpt_step: assert property (
    evt && q.alarm_repeat_count != RST_ZERO && !alm_wr
    |=> q.alarm_repeat_count == $past(q.alarm_repeat_count) - 8'h01)
    else $error("repeat count did not decrement");
  chk_irq_event: assert property (
    evt |=> alarm_irq_o ##1 (!alarm_irq_o || $past(evt)))
    else $error("missing interrupt pulse");
  chk_pulse_toggle: assert property (
    evt |=> q.apulse != $past(q.apulse))
    else $error("alarm pulse did not toggle");

  cov_alarm: cover property (evt ##[1:1000] evt);
  cov_chime: cover property (evt && q.chime && q.alarm_repeat_count == RST_ZERO);
  cov_minute: cover property (sec_tick && q.sec == SEC_MAX);
  cov_unlocked: cover property (wr && reg_off == OFF_TWIN && q.wren);
endmodule // rca_top
`default_nettype wire

// >>> rtl/rca_pkg.sv
// Constants for the clock/calendar block: register offsets, bit
// positions, counter settings, BCD limits and reset values.
// Assumes a 32-bit classic Wishbone slave with byte addresses.
package rca_pkg;
  localparam int DATA_W = 32;
  localparam int SEL_W = 4;
  // Register byte offsets
  localparam logic [7:0] OFF_CFG = 8'h00;
  localparam logic [7:0] OFF_PAD = 8'h04;
  localparam logic [7:0] OFF_ALM = 8'h08;
  localparam logic [7:0] OFF_TWIN = 8'h0c;
  localparam logic [7:0] OFF_AWIN = 8'h10;
  // Bit positions in the config, pad and alarm config words
  localparam int CFG_EN = 15;
  localparam int CFG_WREN = 13;
  localparam int CFG_OE = 10;
  localparam int PTR_HI = 9;
  localparam int PTR_LO = 8;
  localparam int ALM_EN = 15;
  localparam int ALM_CHIME = 14;
  localparam int MASK_HI = 13;
  localparam int MASK_LO = 10;
  localparam int PAD_SECSEL = 1;
  localparam int PAD_BUF = 0;
  // Crystal pulse counter; the bias keeps negative trims positive
  localparam logic [15:0] CNT_BIAS = 16'h0400;
  localparam logic [15:0] CNT_SEC_LAST = CNT_BIAS + 16'h7fff;
  localparam logic [15:0] CNT_HALF = CNT_BIAS + 16'h4000;
  localparam logic [15:0] CNT_RIPPLE = CNT_SEC_LAST - 16'h0020;
  // Alarm interval codes
  localparam logic [3:0] AM_HALF = 4'h0;
  localparam logic [3:0] AM_SEC = 4'h1;
  localparam logic [3:0] AM_10S = 4'h2;
  localparam logic [3:0] AM_MIN = 4'h3;
  localparam logic [3:0] AM_10M = 4'h4;
  localparam logic [3:0] AM_HOUR = 4'h5;
  localparam logic [3:0] AM_DAY = 4'h6;
  localparam logic [3:0] AM_WEEK = 4'h7;
  localparam logic [3:0] AM_MONTH = 4'h8;
  localparam logic [3:0] AM_YEAR = 4'h9;
  // BCD limits and field masks
  localparam logic [7:0] SEC_MAX = 8'h59;
  localparam logic [7:0] HR_MAX = 8'h23;
  localparam logic [7:0] MON_MAX = 8'h12;
  localparam logic [7:0] YR_MAX = 8'h99;
  localparam logic [2:0] WEEKDAY_DIGIT_MAX = 3'h6;
  localparam logic [7:0] M_MS = 8'h7f;
  localparam logic [7:0] M_HD = 8'h3f;
  localparam logic [7:0] M_MON = 8'h1f;
  localparam logic [2:0] M_WD = 3'h7;
  localparam logic [7:0] MON_FEB = 8'h02;
  localparam logic [7:0] MON_APR = 8'h04;
  localparam logic [7:0] MON_JUN = 8'h06;
  localparam logic [7:0] MON_SEP = 8'h09;
  localparam logic [7:0] MON_NOV = 8'h11;
  localparam logic [7:0] DAY_28 = 8'h28;
  localparam logic [7:0] DAY_29 = 8'h29;
  localparam logic [7:0] DAY_30 = 8'h30;
  localparam logic [7:0] DAY_31 = 8'h31;
  // Power-on time: 2000-01-01 00:00:00, a Saturday
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_ONE = 8'h01;
  localparam logic [2:0] RST_WEEKDAY_DIGIT = 3'h6;
  localparam logic [7:0] RPT_MAX = 8'hff;
endpackage

// >>> bench/test_rtc_calendar_alarm.sv
// Self-checking bench for the clock/calendar register block.
// Assumes rca_top with a classic Wishbone slave answering in one cycle.
`timescale 1ns/1ps
`default_nettype none
module test_rtc_calendar_alarm;
  import rca_pkg::*;
  logic clk_i, rst_i, por_i, xtal_i, cyc, stb, we;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat, rd, wb_dat_o;
  logic wb_ack_o, rtc_pin_o, rtc_pin_oe_n_o, alarm_irq_o;
  int n_mismatch, compares, seed, n_wait;
  logic [15:0] ev [2][4];
  logic [15:0] cfg_v, alm_v, v;
  rca_top #(.ADDR_W(8)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .xtal_i(xtal_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .rtc_pin_o(rtc_pin_o),
    .rtc_pin_oe_n_o(rtc_pin_oe_n_o), .alarm_irq_o(alarm_irq_o));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // Crystal of four clock periods: half a second fits the run
  initial begin
    xtal_i = 1'b0;
    forever #20 xtal_i = ~xtal_i;
  end
  task automatic final_report;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [3:0] s, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    dat <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 16);
    if (wb_ack_o !== 1'b1) begin
      n_mismatch++;
      $display("ERROR %0t no bus answer", $time);
      final_report();
    end
    rd = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                     input string m);
    wb(1'b0, a, 4'hf, 32'h0);
    chk(rd, e, m);
  endtask
  function automatic int r(input int n);
    return ($random(seed) & 32'h7fffffff) % n;
  endfunction
  function automatic logic [7:0] bcd(input int x);
    return 8'((x / 10) * 16 + x % 10);
  endfunction
  function automatic logic [15:0] msk(input int k, input int p);
    case (p)
      0: return 16'h7f7f;
      1: return 16'h073f;
      2: return 16'h1f3f;
      default: return (k != 0) ? 16'h0000 : 16'h00ff;
    endcase
  endfunction
  // Alarm config after one event: count down, wrap on chime, else off
  function automatic logic [15:0] evt_cfg(input logic [15:0] a);
    if (a[7:0] != 8'h00) begin
      return {a[15:8], a[7:0] - 8'h01};
    end
    if (a[14]) begin
      return {a[15:8], 8'hff};
    end
    return a & 16'h7fff;
  endfunction
  task automatic setptr(input int k, input logic [1:0] p);
    if (k == 0) begin
      cfg_v[9:8] = p;
      wb(1'b1, OFF_CFG, 4'h3, {16'h0, cfg_v});
    end else begin
      alm_v[9:8] = p;
      wb(1'b1, OFF_ALM, 4'h3, {16'h0, alm_v});
    end
  endtask
  // Fill a window from pointer 3 down, then read it back the same way
  task automatic win(input int k);
    logic [15:0] m;
    logic [7:0] off;
    off = (k != 0) ? OFF_AWIN : OFF_TWIN;
    setptr(k, 2'd3);
    for (int p = 3; p >= 0; p--) begin
      m = msk(k, p);
      case (p)
        0: v = {bcd(r(60)), bcd(r(60))};
        1: v = {5'h0, 3'(r(7)), bcd(r(24))};
        2: v = {bcd(1 + r(12)), bcd(1 + r(28))};
        default: v = {8'h0, bcd(r(100))};
      endcase
      ev[k][p] = v & m;
      wb(1'b1, off, 4'h3, {16'h0, (16'($random(seed)) & ~m) | ev[k][p]});
    end
    if (k == 0) begin
      rdc(OFF_CFG, {16'h0, cfg_v & 16'hfcff}, "tptr");
    end else begin
      rdc(OFF_ALM, {16'h0, alm_v & 16'hfcff}, "aptr");
    end
    setptr(k, 2'd3);
    for (int p = 3; p >= -1; p--) begin
      rdc(off, {16'h0, ev[k][(p < 0) ? 0 : p]}, "win");
    end
    cfg_v[9:8] = 2'd0;
    alm_v[9:8] = 2'd0;
  endtask
  initial begin
    seed = int'(32'h939c8c48);
    n_mismatch = 0;
    compares = 0;
    por_i = 1'b1;
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    dat = 32'h0;
    repeat (2) @(posedge clk_i);
    por_i <= 1'b0;
    rst_i <= 1'b0;
    rdc(OFF_CFG, 32'h0, "cfg por");
    rdc(OFF_ALM, 32'h0, "alm por");
    rdc(OFF_PAD, 32'h0, "pad por");
    chk({31'h0, rtc_pin_oe_n_o}, 32'h1, "oe_n idle");
    cfg_v = {8'h00, 8'(r(256))};
    wb(1'b1, OFF_CFG, 4'h3, {16'h0, cfg_v | 16'h8000});
    rdc(OFF_CFG, {16'h0, cfg_v}, "en locked");
    cfg_v[13] = 1'b1;
    wb(1'b1, OFF_CFG, 4'h3, {16'h0, cfg_v});
    cfg_v[15] = 1'b1;
    wb(1'b1, OFF_CFG, 4'h3, {16'h0, cfg_v});
    rdc(OFF_CFG, {16'h0, cfg_v}, "en set");
    alm_v = {1'b0, 1'(r(2)), 4'h0, 2'b00, 8'(r(256))};
    for (int c = 0; c < 16; c++) begin
      alm_v[13:10] = 4'(c);
      wb(1'b1, OFF_ALM, 4'h3, {16'h0, alm_v});
      rdc(OFF_ALM, {16'h0, alm_v}, "alm cfg");
    end
    win(0);
    win(1);
    rdc(OFF_CFG, {16'h0, cfg_v}, "half flag");
    cfg_v[13] = 1'b0;
    wb(1'b1, OFF_CFG, 4'h3, {16'h0, cfg_v});
    wb(1'b1, OFF_TWIN, 4'h3, {16'h0, bcd(r(60)), bcd(r(60))});
    rdc(OFF_TWIN, {16'h0, ev[0][0]}, "locked");
    wb(1'b1, 8'h14, 4'h3, 32'h0000ffff);
    rdc(8'h14, 32'h0, "unmapped");
    rdc(OFF_CFG, {16'h0, cfg_v}, "cfg kept");
    wb(1'b1, OFF_PAD, 4'h3, 32'h2);
    rdc(OFF_PAD, 32'h2, "pad");
    cfg_v[10] = 1'b1;
    wb(1'b1, OFF_CFG, 4'h3, {16'h0, cfg_v});
    repeat (3) @(posedge clk_i);
    chk({31'h0, rtc_pin_oe_n_o}, 32'h0, "oe_n on");
    wb(1'b1, OFF_PAD, 4'h3, 32'h0);
    repeat (3) @(posedge clk_i);
    chk({31'h0, rtc_pin_o}, 32'h0, "pin alarm");
    // Half-second alarm from a restarted second
    cfg_v[13] = 1'b1;
    wb(1'b1, OFF_CFG, 4'h3, {16'h0, cfg_v});
    wb(1'b1, OFF_TWIN, 4'h1, {24'h0, bcd(r(60))});
    alm_v = {1'b1, 1'(r(2)), AM_HALF, 2'b00, 8'(r(2))};
    wb(1'b1, OFF_ALM, 4'h3, {16'h0, alm_v});
    n_wait = 0;
    while (alarm_irq_o !== 1'b1 && n_wait < 70000) begin
      @(posedge clk_i);
      n_wait++;
    end
    chk({31'h0, alarm_irq_o}, 32'h1, "irq");
    if (n_wait >= 70000) begin
      final_report();
    end
    chk({31'h0, rtc_pin_o}, 32'h1, "pin pulse");
    @(posedge clk_i);
    chk({31'h0, alarm_irq_o}, 32'h0, "irq pulse");
    rdc(OFF_ALM, {16'h0, evt_cfg(alm_v)}, "alm evt");
    rdc(OFF_CFG, {16'h0, cfg_v | 16'h0800}, "half set");
    wb(1'b1, OFF_PAD, 4'h3, 32'h2);
    chk({31'h0, rtc_pin_o}, 32'h0, "pin second half");
    wb(1'b1, OFF_TWIN, 4'h1, {24'h0, bcd(r(60))});
    chk({31'h0, rtc_pin_o}, 32'h1, "pin first half");
    rdc(OFF_CFG, {16'h0, cfg_v}, "half cleared");
    cfg_v[10] = 1'b0;
    wb(1'b1, OFF_CFG, 4'h3, {16'h0, cfg_v});
    repeat (3) @(posedge clk_i);
    chk({31'h0, rtc_pin_oe_n_o}, 32'h1, "oe_n off");
    wb(1'b1, OFF_PAD, 4'h3, 32'h3);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(OFF_CFG, {16'h0, cfg_v}, "cfg rst");
    rdc(OFF_ALM, 32'h0, "alm rst");
    rdc(OFF_PAD, 32'h0, "pad rst");
    chk({31'h0, alarm_irq_o}, 32'h0, "no irq");
    por_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    por_i <= 1'b0;
    rdc(OFF_CFG, 32'h0, "cfg por2");
    final_report();
  end
endmodule // test_rtc_calendar_alarm
`default_nettype wire
